//--- flash_ctrl_pkg.sv
// Purpose: constants and types shared by the flash page erase/program controller
// Assumes: one system clock, registers reached over a plain strobe port
// Notes:   the flash array itself lies outside; it is reached over a word port
package flash_ctrl_pkg;
   // ==========================================================
   // register offsets (byte addresses)
   localparam logic [7:0]  OFS_CONTROL   = 8'h00;
   localparam logic [7:0]  OFS_STATUS    = 8'h04;
   localparam logic [7:0]  OFS_ADDRESS   = 8'h08;
   localparam logic [7:0]  OFS_WDATA     = 8'h0c;
   localparam logic [7:0]  OFS_COMMAND   = 8'h10;
   localparam logic [7:0]  OFS_DIECFG    = 8'h14;
   localparam logic [7:0]  OFS_RDATA     = 8'h18;
   // ==========================================================
   // field positions
   localparam int          CM_LSB        = 0;
   localparam int          BUSY_BIT      = 0;
   localparam int          ERR_BIT       = 1;
   localparam int          ILLEGAL_BIT   = 2;
   localparam int          DONE_BIT      = 3;
   localparam int          SRAM_LSB      = 16;
   // ==========================================================
   // geometry: 2 kB pages of 512 words
   localparam int          PAGE_WORDS    = 512;
   localparam int          WADDR_W       = 17;
   localparam int          PAGE_IDX_W    = 8;
   localparam logic [8:0]  LAST_WORD     = 9'h1ff;
   localparam logic [31:0] ERASED_WORD   = 32'hffffffff;
   // sizes in kilobytes (plain defaults)
   localparam logic [15:0] FLASH_KB      = 16'h0200;
   localparam logic [15:0] SRAM_KB       = 16'h0020;
   localparam logic [PAGE_IDX_W-1:0] UPPER_PAGE = 8'hff;
   // reset values
   localparam logic [1:0]  CM_RESET      = 2'h1;
   // ==========================================================
   typedef enum logic [1:0] {
      CACHE_OFF, CACHE_ON, CACHE_PREFETCH, CACHE_REALTIME
   } cache_mode_t;
   localparam logic [1:0]  cache_prefetch_code = 2'h2;
   // command codes written to the command register
   localparam logic [2:0]  CMD_MAIN_ERASE  = 3'h1;
   localparam logic [2:0]  CMD_MAIN_PROG   = 3'h2;
   localparam logic [2:0]  CMD_UPPER_ERASE = 3'h3;
   localparam logic [2:0]  CMD_UPPER_PROG  = 3'h4;
   localparam logic [2:0]  CMD_READ        = 3'h5;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ERASE, ST_PROG_RD, ST_PROG_WR, ST_READ
   } seq_state_t;
endpackage : flash_ctrl_pkg

//--- flash_page_erase_program_ctrl.sv
// Purpose: sequencer that erases 2 kB pages and programs words of an external flash array
// Assumes: array answers reads in the cycle after fl_rd; lock bits come in per page
// Notes:   one command at a time; commands while busy are ignored
//
// The address map and the address-and-strobe port were left to the implementer.
module flash_page_erase_program_ctrl
   import flash_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  resetn,
   input  wire logic                  clk_en,
   // register port
   input  wire logic [7:0]            reg_addr,
   input  wire logic [31:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [31:0]           reg_rdata,
   // flash array port
   output logic      [WADDR_W-1:0]    fl_addr,
   output logic      [31:0]           fl_wdata,
   output logic                       fl_wr,
   output logic                       fl_rd,
   input  wire logic [31:0]           fl_rdata,
   input  wire logic [PAGE_IDX_W-1:0] top_page,
   input  wire logic                  page_locked,
   // cache control
   output logic      [1:0]            cache_mode,
   output logic                       cache_fixed_timing
);
   // ==========================================================
   // state
   seq_state_t             state_reg, state_next;
   logic [1:0]             cm_reg, cm_next;
   logic [WADDR_W-1:0]     addr_reg, addr_next;
   logic [31:0]            wdata_reg, wdata_next;
   logic [31:0]            rdbuf_reg, rdbuf_next;
   logic                   err_reg, err_next;
   logic                   ill_reg, ill_next;
   logic                   done_reg, done_next;
   logic [31:0]            rdata_reg, rdata_next;
   logic [8:0]             cnt_reg, cnt_next;
   logic                   read_pending_reg;

   logic [PAGE_IDX_W-1:0]  req_page;
   logic                   is_upper;
   logic                   cmd_wr;
   logic [31:0]            rd_mux;

   // decoded page of the requested address
   assign req_page = addr_reg[WADDR_W-1 -: PAGE_IDX_W];
   assign is_upper = (req_page == top_page);
   assign cmd_wr   = reg_wr && (reg_addr == OFS_COMMAND) && (state_reg == ST_IDLE);

   // ==========================================================
   // read multiplexer
   always_comb begin
      rd_mux = 32'h0;
      unique case (reg_addr)
         OFS_CONTROL: rd_mux = {30'h0, cm_reg};
         OFS_STATUS:  rd_mux = {28'h0, done_reg, ill_reg, err_reg,
                                (state_reg != ST_IDLE)};
         OFS_ADDRESS: rd_mux = {13'h0, addr_reg, 2'h0};
         OFS_WDATA:   rd_mux = wdata_reg;
         OFS_DIECFG:  rd_mux = {SRAM_KB, FLASH_KB};
         OFS_RDATA:   rd_mux = rdbuf_reg;
         default:     rd_mux = 32'h0;
      endcase
   end

   // ==========================================================
   // next-state logic for the sequencer and registers
   always_comb begin
      state_next = state_reg;
      cm_next    = cm_reg;
      addr_next  = addr_reg;
      wdata_next = wdata_reg;
      rdbuf_next = rdbuf_reg;
      err_next   = err_reg;
      ill_next   = ill_reg;
      done_next  = done_reg;
      cnt_next   = cnt_reg;
      rdata_next = reg_rd ? rd_mux : 32'h0;
      fl_addr    = addr_reg;
      fl_wdata   = ERASED_WORD;
      fl_wr      = 1'b0;
      fl_rd      = 1'b0;
      // software writes; status write-one clears, hardware set wins below
      if (reg_wr) begin
         unique case (reg_addr)
            OFS_CONTROL: cm_next = reg_wdata[CM_LSB +: 2];
            OFS_ADDRESS: if (state_reg == ST_IDLE) begin
               addr_next = reg_wdata[WADDR_W+1:2];
            end
            OFS_WDATA:   if (state_reg == ST_IDLE) begin
               wdata_next = reg_wdata;
            end
            OFS_STATUS: begin
               if (reg_wdata[ERR_BIT]) begin
                  err_next = 1'b0;
               end
               if (reg_wdata[ILLEGAL_BIT]) begin
                  ill_next = 1'b0;
               end
               if (reg_wdata[DONE_BIT]) begin
                  done_next = 1'b0;
               end
            end
            default: ;
         endcase
      end
      unique case (state_reg)
         ST_IDLE: begin
            if (cmd_wr) begin
               done_next = 1'b0;
               unique case (reg_wdata[2:0])
                  CMD_MAIN_ERASE, CMD_MAIN_PROG: begin
                     if (is_upper) begin
                        ill_next  = 1'b1;
                        err_next  = 1'b1;
                        done_next = 1'b1;
                     end else if (page_locked) begin
                        err_next  = 1'b1;
                        done_next = 1'b1;
                     end else if (reg_wdata[2:0] == CMD_MAIN_ERASE) begin
                        addr_next  = {req_page, 9'h0};
                        cnt_next   = 9'h0;
                        state_next = ST_ERASE;
                     end else begin
                        state_next = ST_PROG_RD;
                     end
                  end
                  CMD_UPPER_ERASE: begin
                     addr_next = {top_page, 9'h0};
                     // lock looked up for the upper page, not the address register
                     fl_addr   = {top_page, 9'h0};
                     if (page_locked) begin
                        err_next  = 1'b1;
                        done_next = 1'b1;
                     end else begin
                        cnt_next   = 9'h0;
                        state_next = ST_ERASE;
                     end
                  end
                  CMD_UPPER_PROG: begin
                     if (!is_upper) begin
                        ill_next  = 1'b1;
                        err_next  = 1'b1;
                        done_next = 1'b1;
                     end else if (page_locked) begin
                        err_next  = 1'b1;
                        done_next = 1'b1;
                     end else begin
                        state_next = ST_PROG_RD;
                     end
                  end
                  CMD_READ: state_next = ST_READ;
                  default: begin
                     ill_next  = 1'b1;
                     done_next = 1'b1;
                  end
               endcase
            end
         end
         ST_ERASE: begin
            fl_wr    = 1'b1;
            fl_wdata = ERASED_WORD;
            addr_next = addr_reg + {{(WADDR_W-1){1'b0}}, 1'b1};
            cnt_next  = cnt_reg + 9'h1;
            if (cnt_reg == LAST_WORD) begin
               addr_next  = addr_reg;
               state_next = ST_IDLE;
               done_next  = 1'b1;
            end
         end
         ST_PROG_RD: begin
            fl_rd      = 1'b1;
            state_next = ST_PROG_WR;
         end
         ST_PROG_WR: begin
            fl_wr      = 1'b1;
            fl_wdata   = fl_rdata & wdata_reg;
            state_next = ST_IDLE;
            done_next  = 1'b1;
         end
         ST_READ: begin
            fl_rd      = 1'b1;
            state_next = ST_IDLE;
         end
      endcase
      // done rises as the read strobe ends, one cycle before the word reaches the read buffer
      if (state_reg == ST_READ && state_next == ST_IDLE) begin
         done_next = 1'b1;
      end
      // array word arrives in the cycle after the read strobe
      if (read_pending_reg) begin
         rdbuf_next = fl_rdata;
      end
   end

   // ==========================================================
   // marks the cycle in which the word of a read command is answered
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         read_pending_reg <= 1'b0;
      end else if (clk_en) begin
         read_pending_reg <= (state_reg == ST_READ);
      end
   end

   // ==========================================================
   // state registers
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state_reg <= ST_IDLE;
         cm_reg    <= CM_RESET;
         addr_reg  <= '0;
         wdata_reg <= 32'h0;
         rdbuf_reg <= 32'h0;
         err_reg   <= 1'b0;
         ill_reg   <= 1'b0;
         done_reg  <= 1'b0;
         rdata_reg <= 32'h0;
         cnt_reg   <= 9'h0;
      end else if (clk_en) begin
         state_reg <= state_next;
         cm_reg    <= cm_next;
         addr_reg  <= addr_next;
         wdata_reg <= wdata_next;
         rdbuf_reg <= rdbuf_next;
         err_reg   <= err_next;
         ill_reg   <= ill_next;
         done_reg  <= done_next;
         rdata_reg <= rdata_next;
         cnt_reg   <= cnt_next;
      end
   end

   assign reg_rdata          = rdata_reg;
   assign cache_mode         = cm_reg;
   assign cache_fixed_timing = (cm_reg == CACHE_REALTIME)
                               || (cm_reg == CACHE_OFF);

   // ==========================================================
   // checks
   a_erase_length: assert property (@(posedge sys_clk) disable iff (!resetn || !clk_en)
      ($rose(state_reg == ST_ERASE)) |-> (state_reg == ST_ERASE) [*8])
      else $error("erase ended too early");
   a_erase_ones: assert property (@(posedge sys_clk) disable iff (!resetn)
      (state_reg == ST_ERASE) |-> (fl_wr && fl_wdata == ERASED_WORD))
      else $error("erase wrote a non-erased word");
   a_lock_refuse: assert property (@(posedge sys_clk) disable iff (!resetn || !clk_en)
      (cmd_wr && page_locked && reg_wdata[2:0] == CMD_UPPER_ERASE)
      |=> (state_reg == ST_IDLE && err_reg))
      else $error("locked erase not refused");
   a_upper_illegal: assert property (@(posedge sys_clk) disable iff (!resetn || !clk_en)
      (cmd_wr && is_upper && reg_wdata[2:0] == CMD_MAIN_ERASE) |=> ill_reg)
      else $error("main erase of upper page not flagged");
   a_prog_and: assert property (@(posedge sys_clk) disable iff (!resetn)
      (state_reg == ST_PROG_WR) |-> (fl_wdata == (fl_rdata & wdata_reg)))
      else $error("programmed word is not the AND");
   a_no_raise: assert property (@(posedge sys_clk) disable iff (!resetn)
      (state_reg == ST_PROG_WR) |-> ((fl_wdata & ~fl_rdata) == 32'h0))
      else $error("program raised a zero bit");
   a_lock_prog: assert property (@(posedge sys_clk) disable iff (!resetn || !clk_en)
      (cmd_wr && page_locked && !is_upper && reg_wdata[2:0] == CMD_MAIN_PROG)
      |=> (err_reg && state_reg == ST_IDLE))
      else $error("locked program not refused");
   a_mode_read: assert property (@(posedge sys_clk) disable iff (!resetn || !clk_en)
      (reg_rd && reg_addr == OFS_CONTROL) |=> (reg_rdata[1:0] == $past(cm_reg)))
      else $error("cache mode readback wrong");
   a_err_sticky: assert property (@(posedge sys_clk) disable iff (!resetn || !clk_en)
      (err_reg && !(reg_wr && reg_addr == OFS_STATUS)) |=> err_reg)
      else $error("error flag dropped without a clear");
   a_busy_status: assert property (@(posedge sys_clk) disable iff (!resetn || !clk_en)
      (reg_rd && reg_addr == OFS_STATUS && state_reg != ST_IDLE)
      |=> reg_rdata[BUSY_BIT])
      else $error("busy not reported while running");
   a_erase_done: assert property (@(posedge sys_clk) disable iff (!resetn || !clk_en)
      (state_reg == ST_ERASE && cnt_reg == LAST_WORD) |=> (state_reg == ST_IDLE && done_reg))
      else $error("erase end not reported");
   a_upper_lock: assert property (@(posedge sys_clk) disable iff (!resetn)
      (cmd_wr && reg_wdata[2:0] == CMD_UPPER_ERASE)
      |-> (fl_addr[WADDR_W-1 -: PAGE_IDX_W] == top_page))
      else $error("upper erase lock taken from wrong page");
endmodule // flash_page_erase_program_ctrl

//--- flash_array_model.sv
// Purpose: behavioural flash array with one lockable page
// Assumes: word reads are answered in the cycle after fl_rd
// Notes:   unwritten words read as erased ones
module flash_array_model
   import flash_ctrl_pkg::*;
(
   // array port
   input  wire logic                  sys_clk,
   input  wire logic [WADDR_W-1:0]    fl_addr,
   input  wire logic [31:0]           fl_wdata,
   input  wire logic                  fl_wr,
   input  wire logic                  fl_rd,
   output logic      [31:0]           fl_rdata,
   // lock setup from the bench
   input  wire logic [PAGE_IDX_W-1:0] lock_idx,
   input  wire logic                  lock_on,
   output logic      [PAGE_IDX_W-1:0] top_page,
   output logic                       page_locked
);
   timeunit 1ns;
   timeprecision 1ns;
   // =======================================
   // storage and lock
   logic [31:0] mem [int];
   initial fl_rdata = 32'h0;
   // config and lock page sits at the top index
   assign top_page    = UPPER_PAGE;
   assign page_locked = lock_on && (fl_addr[16:9] == lock_idx);
   // stored word, or erased ones
   function automatic logic [31:0] peek(input int a);
      return mem.exists(a) ? mem[a] : ERASED_WORD;
   endfunction
   // writes land at once; read answers next cycle, idle line toggles
   always @(posedge sys_clk) begin
      if (fl_wr === 1'b1)
         mem[int'(fl_addr)] = fl_wdata;
      if (fl_rd === 1'b1)
         fl_rdata <= peek(int'(fl_addr));
      else
         fl_rdata <= ~fl_rdata;
   end
endmodule // flash_array_model

//--- flash_page_erase_program_ctrl_tb.sv
// Purpose: register-level tests of the flash erase/program controller
// Assumes: array model on the far side, clk_en held high except in the frozen control-write test
// Notes:   status flags are cleared before each command
module flash_page_erase_program_ctrl_tb
   import flash_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // =======================================
   // signals
   logic               sys_clk, resetn, reg_wr, reg_rd, fl_wr, fl_rd;
   logic               lock_on, page_locked, cfix, en;
   logic [7:0]         reg_addr, top_page, lock_idx;
   logic [31:0]        reg_wdata, reg_rdata, fl_wdata, fl_rdata, rd, st, first_st;
   logic [WADDR_W-1:0] fl_addr;
   logic [1:0]         cache_mode;
   int                 n_fail, cmp_count, wr_cnt;
   localparam logic [31:0] PG4 = 32'h00002000; // page 4, word 0
   localparam logic [31:0] UPG = 32'h0007f800; // upper page, word 0
   // =======================================
   // instances
   flash_page_erase_program_ctrl dut_u (.sys_clk(sys_clk), .resetn(resetn),
      .clk_en(en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
      .fl_wr(fl_wr), .fl_rd(fl_rd), .fl_rdata(fl_rdata), .top_page(top_page),
      .page_locked(page_locked), .cache_mode(cache_mode), .cache_fixed_timing(cfix));
   flash_array_model arr_u (.sys_clk(sys_clk), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
      .fl_wr(fl_wr), .fl_rd(fl_rd), .fl_rdata(fl_rdata), .lock_idx(lock_idx),
      .lock_on(lock_on), .top_page(top_page), .page_locked(page_locked));
   // clock and array write counter
   always #25 sys_clk = ~sys_clk;
   always @(negedge sys_clk) if (fl_wr === 1'b1) wr_cnt++;
   // =======================================
   // access tasks
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      @(negedge sys_clk);
      d = reg_rdata;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // clear flags, issue one command, poll busy with a bound
   task automatic do_cmd(input logic [2:0] c, input logic [31:0] a, input logic [31:0] d);
      reg_write(OFS_STATUS, 32'h0000000f);
      reg_write(OFS_ADDRESS, a);
      reg_write(OFS_WDATA, d);
      reg_write(OFS_COMMAND, {29'h0, c});
      st = 32'h00000001;
      for (int i = 0; i < 2000 && st[BUSY_BIT] !== 1'b0; i++) begin
         reg_read(OFS_STATUS, st);
         if (i == 0)
            first_st = st;
      end
   endtask
   task automatic fl_check(input logic [31:0] a, input logic [31:0] exp);
      do_cmd(CMD_READ, a, 32'h0);
      reg_read(OFS_RDATA, rd);
      check("flash word", rd, exp);
   endtask
   task automatic set_lock(input logic on, input logic [7:0] idx);
      @(posedge sys_clk);
      lock_on  <= on;
      lock_idx <= idx;
   endtask
   task automatic report_and_stop();
      if (n_fail == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // =======================================
   // watchdog, more than ten times the expected run length
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      report_and_stop();
   end
   // =======================================
   // test sequence
   initial begin
      {sys_clk, resetn, reg_wr, reg_rd, lock_on, en} = 6'h01;
      {reg_addr, lock_idx, reg_wdata} = 48'h0;
      {n_fail, cmp_count, wr_cnt} = '0;
      repeat (10) @(posedge sys_clk);
      resetn <= 1'b1;
      reg_read(OFS_CONTROL, rd);
      check("cm reset", rd, {30'h0, CM_RESET});
      reg_read(OFS_STATUS, rd);
      check("status reset", rd, 32'h0);
      // size word twice: reading has no side effect
      for (int k = 0; k < 2; k++) begin
         reg_read(OFS_DIECFG, rd);
         check("diecfg", rd, {SRAM_KB, FLASH_KB});
      end
      reg_read(8'h1c, rd);
      check("unmapped", rd, 32'h0);
      // every cache mode by read-modify-write
      for (int m = 0; m < 4; m++) begin
         reg_read(OFS_CONTROL, rd);
         reg_write(OFS_CONTROL, (rd & 32'hfffffffc) | 32'(m));
         reg_read(OFS_CONTROL, rd);
         check("cm readback", rd, 32'(m));
         check("cm port", cache_mode, 32'(m));
         check("fixed timing", cfix, 32'(m == 0 || m == 3));
      end
      // clock enable low: a control write is not taken
      en <= 1'b0;
      reg_write(OFS_CONTROL, 32'h0);
      en <= 1'b1;
      reg_read(OFS_CONTROL, rd);
      check("frozen cm", rd, 32'h3);
      // program twice: AND of old and new
      do_cmd(CMD_MAIN_PROG, PG4, 32'h12345678);
      check("prog st", st, 32'h8);
      do_cmd(CMD_MAIN_PROG, PG4, 32'hff00ff00);
      check("prog zero-to-one st", st, 32'h8);
      fl_check(PG4, 32'h12005600);
      do_cmd(CMD_MAIN_PROG, PG4 + 32'h800, 32'h00c0ffee);
      // erase whole page 4, neighbour untouched
      wr_cnt = 0;
      do_cmd(CMD_MAIN_ERASE, PG4, 32'h0);
      check("erase st", st, 32'h8);
      check("erase busy", first_st[BUSY_BIT], 32'h1);
      check("erase words", wr_cnt, PAGE_WORDS);
      fl_check(PG4, ERASED_WORD);
      fl_check(PG4 + 32'h7fc, ERASED_WORD);
      fl_check(PG4 + 32'h800, 32'h00c0ffee);
      // locked page: refusals, sticky error, clear
      do_cmd(CMD_MAIN_PROG, PG4, 32'h0f0f0f0f);
      set_lock(1'b1, 8'h04);
      do_cmd(CMD_MAIN_PROG, PG4, 32'h0);
      check("locked prog", st, 32'ha);
      reg_read(OFS_STATUS, rd);
      check("sticky err", rd, 32'ha);
      reg_write(OFS_STATUS, 32'h2);
      reg_read(OFS_STATUS, rd);
      check("err cleared", rd, 32'h8);
      do_cmd(CMD_MAIN_ERASE, PG4, 32'h0);
      check("locked erase", st, 32'ha);
      fl_check(PG4, 32'h0f0f0f0f);
      set_lock(1'b0, 8'h00);
      // illegal parameters and unknown command
      do_cmd(CMD_MAIN_ERASE, UPG, 32'h0);
      check("main on upper", st, 32'he);
      do_cmd(CMD_MAIN_PROG, UPG, 32'h0);
      check("main prog upper", st, 32'he);
      do_cmd(CMD_UPPER_PROG, PG4, 32'h0);
      check("upper outside", st, 32'he);
      do_cmd(3'h7, PG4, 32'h0);
      check("unknown cmd", st, 32'hc);
      // upper page program, locked erase, erase
      do_cmd(CMD_UPPER_PROG, UPG + 32'hc, 32'h0000abcd);
      check("upper prog st", st, 32'h8);
      fl_check(UPG + 32'hc, 32'h0000abcd);
      set_lock(1'b1, UPPER_PAGE);
      do_cmd(CMD_UPPER_ERASE, PG4, 32'h0);
      check("upper locked", st, 32'ha);
      set_lock(1'b0, 8'h00);
      do_cmd(CMD_UPPER_ERASE, UPG, 32'h0);
      check("upper erase st", st, 32'h8);
      fl_check(UPG + 32'hc, ERASED_WORD);
      report_and_stop();
   end
endmodule // flash_page_erase_program_ctrl_tb
